// >>> efb_params.svh
`ifndef EFB_PARAMS_SVH
`define EFB_PARAMS_SVH
// register offsets inside the embedded bank
`define OFS_FEATURE_PAGE_SELECT 8'h02
`define OFS_FUNCTION_ENABLE_A 8'h04
`define OFS_FUNCTION_ENABLE_B 8'h05
`define OFS_EXECUTION_STATUS 8'h07
`define OFS_INDIRECT_PAGE_ADDRESS 8'h08
`define OFS_INDIRECT_PAGE_VALUE 8'h09
`define OFS_FIRST_PIN_FUNCTION_ROUTING 8'h0A
`define OFS_FIRST_PIN_STATE_MACHINE_ROUTING 8'h0B
`define OFS_FIRST_PIN_LEARNING_CORE_ROUTING 8'h0D
`define OFS_SECOND_PIN_FUNCTION_ROUTING 8'h0E
// reset values
`define RST_FEATURE_PAGE_SELECT 8'h01
`define RST_ZERO 8'h00
// writable bit masks, reserved positions stay zero
`define MASK_FUNCTION_ENABLE_A 8'hBA
`define MASK_FUNCTION_ENABLE_B 8'h19
`define MASK_FUNCTION_ROUTING 8'hB8
`define MASK_LEARNING_CORE_ROUTING 8'h0F
// field positions, enable register a
`define BIT_LEARNING_CORE_FIRST 7
`define BIT_SIGNIFICANT_MOTION 5
`define BIT_TILT 4
`define BIT_STEP_COUNTER 3
`define BIT_FUSION_ROTATION 1
// field positions, enable register b
`define BIT_LEARNING_CORE_AFTER 4
`define BIT_QUEUE_COMPRESSION 3
`define BIT_STATE_MACHINE 0
// field positions, execution status
`define BIT_EXECUTION_OVERRUN 1
`define BIT_EXECUTION_IDLE 0
// field positions, function routing
`define BIT_LONG_COUNTER_ROUTE 7
`define BIT_SIGNIFICANT_MOTION_ROUTE 5
`define BIT_TILT_ROUTE 4
`define BIT_STEP_ROUTE 3
// page select nibble
`define PAGE_SELECT_MSB 7
`define PAGE_SELECT_LSB 4
// cycles spent in each stage of a processing pass
`define STAGE_CYCLES 4
`endif

// >>> efb_pkg.sv
package efb_pkg;
  // stage of one embedded processing pass
  typedef enum logic [2:0] {
    EXEC_IDLE,
    EXEC_LC_FIRST,
    EXEC_SM,
    EXEC_LC_AFTER,
    EXEC_ALGO
  } exec_stage_e;
  // one register byte
  typedef logic [7:0] byte_t;
endpackage

// >>> page_mem_if.sv
`timescale 1ns/1ps
interface page_mem_if #(
  parameter int AW = 12
);
  logic wr_en; // one-cycle write strobe
  logic [AW-1:0] addr; // page select and page address
  logic [7:0] wdata; // byte to store
  logic [7:0] rdata; // registered byte at addr
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> page_memory.sv
`timescale 1ns/1ps
module page_memory #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // access port
  page_mem_if.mem port
);
  // storage of all advanced-feature pages, left unreset to stay a plain ram
  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rdata_q;

  // write port
  always_ff @(posedge core_clk_in) begin
    if (port.wr_en) begin
      store[port.addr] <= port.wdata;
    end
  end

  // registered read, follows the address one cycle late
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= store[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule

// >>> exec_sequencer.sv
`timescale 1ns/1ps
`include "efb_params.svh"
module exec_sequencer #(
  parameter int STAGE_LEN = `STAGE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // pass trigger and enables
  input wire logic sample_tick_in,
  input wire logic lc_first_en_in,
  input wire logic sm_en_in,
  input wire logic lc_after_en_in,
  input wire logic algo_en_in,
  // pass state
  output efb_pkg::exec_stage_e stage_out,
  output logic busy_out,
  output logic overrun_out
);
  import efb_pkg::*;
  exec_stage_e stage_q, stage_d, next_stage;
  logic [7:0] cnt_q, cnt_d;
  logic stage_end;

  // order of a pass: learning core first, state machines, learning core after, algorithms
  always_comb begin
    next_stage = EXEC_IDLE;
    case (stage_q)
      EXEC_IDLE: begin
        if (lc_first_en_in) next_stage = EXEC_LC_FIRST;
        else if (sm_en_in) next_stage = EXEC_SM;
        else if (lc_after_en_in) next_stage = EXEC_LC_AFTER;
        else if (algo_en_in) next_stage = EXEC_ALGO;
      end
      EXEC_LC_FIRST: begin
        if (sm_en_in) next_stage = EXEC_SM;
        else if (algo_en_in) next_stage = EXEC_ALGO;
      end
      EXEC_SM: begin
        if (lc_after_en_in) next_stage = EXEC_LC_AFTER;
        else if (algo_en_in) next_stage = EXEC_ALGO;
      end
      EXEC_LC_AFTER: begin
        if (algo_en_in) next_stage = EXEC_ALGO;
      end
      default: next_stage = EXEC_IDLE;
    endcase
  end

  assign stage_end = (cnt_q == 8'(STAGE_LEN - 1));
  assign busy_out = (stage_q != EXEC_IDLE);
  // a new sample while busy means the pass ran too long; that sample is dropped
  assign overrun_out = sample_tick_in & busy_out;

  // stage advance
  always_comb begin
    stage_d = stage_q;
    cnt_d = cnt_q;
    if (stage_q == EXEC_IDLE) begin
      if (sample_tick_in) begin
        stage_d = next_stage;
        cnt_d = 8'h00;
      end
    end else if (stage_end) begin
      stage_d = next_stage;
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_q <= EXEC_IDLE;
      cnt_q <= 8'h00;
    end else begin
      stage_q <= stage_d;
      cnt_q <= cnt_d;
    end
  end

  assign stage_out = stage_q;
endmodule

// >>> embedded_function_control_bank.sv
`timescale 1ns/1ps
`include "efb_params.svh"
module embedded_function_control_bank #(
  parameter int PAGE_ADDR_W = 12,
  parameter int STAGE_LEN = `STAGE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // register port from the serial interface
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output efb_pkg::byte_t reg_rdata_out,
  // control bits held in registers outside this bank
  input wire logic embedded_bank_access_in,
  input wire logic runtime_compression_enable_in,
  input wire logic page_write_mode_in,
  input wire logic page_read_mode_in,
  input wire logic function_interrupt_latch_in,
  input wire logic first_pin_function_gate_in,
  input wire logic second_pin_function_gate_in,
  // processing trigger and service
  input wire logic sample_tick_in,
  input wire logic interrupt_service_in,
  // embedded events, one-cycle pulses
  input wire logic long_counter_event_in,
  input wire logic significant_motion_event_in,
  input wire logic tilt_event_in,
  input wire logic step_event_in,
  input wire logic [7:0] state_machine_event_in,
  input wire logic [3:0] learning_core_event_in,
  // function run controls
  output logic significant_motion_run_out,
  output logic tilt_run_out,
  output logic step_counter_run_out,
  output logic fusion_rotation_run_out,
  output logic queue_compression_active_out,
  output logic state_machine_run_out,
  output logic learning_core_run_out,
  output efb_pkg::exec_stage_e exec_stage_out,
  // interrupt pins
  output logic first_interrupt_pin_out,
  output logic second_interrupt_pin_out
);
  import efb_pkg::*;

  // bank registers
  byte_t page_select_q; // page nibble plus bit zero
  byte_t enable_a_q; // function enables a
  byte_t enable_b_q; // function enables b
  byte_t page_address_q; // location inside page
  byte_t page_value_q; // last byte written to the value register
  byte_t fn1_route_q; // first pin function routing
  byte_t sm1_route_q; // first pin state machine routing
  byte_t lc1_route_q; // first pin learning core routing
  byte_t fn2_route_q; // second pin function routing
  byte_t rdata_q; // read answer
  logic overrun_q; // sticky overrun flag
  logic idle_q; // no processing pass in progress
  logic [15:0] latched_q; // held event requests
  logic pin1_q; // first pin level
  logic pin2_q; // second pin level

  // sequencer outputs
  exec_stage_e stage;
  logic seq_busy;
  logic seq_overrun;

  // indirect page memory carrier
  page_mem_if #(.AW(PAGE_ADDR_W)) pmem ();

  // bank gate
  // every access is dropped while the bank is not selected
  wire access_ok = embedded_bank_access_in;
  wire wr_ok = reg_wr_in & access_ok;
  wire rd_ok = reg_rd_in & access_ok;

  // write decode
  wire wr_page_select = wr_ok & (reg_addr_in == `OFS_FEATURE_PAGE_SELECT);
  wire wr_enable_a = wr_ok & (reg_addr_in == `OFS_FUNCTION_ENABLE_A);
  wire wr_enable_b = wr_ok & (reg_addr_in == `OFS_FUNCTION_ENABLE_B);
  wire wr_page_address = wr_ok & (reg_addr_in == `OFS_INDIRECT_PAGE_ADDRESS);
  wire wr_page_value = wr_ok & (reg_addr_in == `OFS_INDIRECT_PAGE_VALUE);
  wire wr_fn1 = wr_ok & (reg_addr_in == `OFS_FIRST_PIN_FUNCTION_ROUTING);
  wire wr_sm1 = wr_ok & (reg_addr_in == `OFS_FIRST_PIN_STATE_MACHINE_ROUTING);
  wire wr_lc1 = wr_ok & (reg_addr_in == `OFS_FIRST_PIN_LEARNING_CORE_ROUTING);
  wire wr_fn2 = wr_ok & (reg_addr_in == `OFS_SECOND_PIN_FUNCTION_ROUTING);
  // status read clears the overrun flag
  wire rd_status = rd_ok & (reg_addr_in == `OFS_EXECUTION_STATUS);

  // page selection
  // memory address is the page nibble on top of the page address
  wire [3:0] page_nibble = page_select_q[`PAGE_SELECT_MSB:`PAGE_SELECT_LSB];
  // page location
  // address register picks the byte inside the chosen page
  assign pmem.addr = PAGE_ADDR_W'({page_nibble, page_address_q});
  assign pmem.wdata = reg_wdata_in;
  assign pmem.wr_en = wr_page_value & page_write_mode_in;

  // status layout
  // reserved status positions are built as zero
  byte_t status_view;
  always_comb begin
    status_view = `RST_ZERO;
    status_view[`BIT_EXECUTION_OVERRUN] = overrun_q;
    status_view[`BIT_EXECUTION_IDLE] = idle_q;
  end

  // read mode gate
  // without read mode the held value byte is returned instead of page data
  wire [7:0] value_view = page_read_mode_in ? pmem.rdata : page_value_q;

  // read selection
  byte_t read_mux;
  always_comb begin
    case (reg_addr_in)
      `OFS_FEATURE_PAGE_SELECT: read_mux = page_select_q;
      `OFS_FUNCTION_ENABLE_A: read_mux = enable_a_q;
      `OFS_FUNCTION_ENABLE_B: read_mux = enable_b_q;
      `OFS_EXECUTION_STATUS: read_mux = status_view;
      `OFS_INDIRECT_PAGE_ADDRESS: read_mux = page_address_q;
      `OFS_INDIRECT_PAGE_VALUE: read_mux = value_view;
      `OFS_FIRST_PIN_FUNCTION_ROUTING: read_mux = fn1_route_q;
      `OFS_FIRST_PIN_STATE_MACHINE_ROUTING: read_mux = sm1_route_q;
      `OFS_FIRST_PIN_LEARNING_CORE_ROUTING: read_mux = lc1_route_q;
      `OFS_SECOND_PIN_FUNCTION_ROUTING: read_mux = fn2_route_q;
      default: read_mux = `RST_ZERO; // unmapped reads zero
    endcase
  end

  // configuration reset and write
  // configuration registers; enable and routing writes drop reserved bits, page select keeps the whole byte
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_select_q <= `RST_FEATURE_PAGE_SELECT;
      enable_a_q <= `RST_ZERO;
      enable_b_q <= `RST_ZERO;
      page_address_q <= `RST_ZERO;
      page_value_q <= `RST_ZERO;
      fn1_route_q <= `RST_ZERO;
      sm1_route_q <= `RST_ZERO;
      lc1_route_q <= `RST_ZERO;
      fn2_route_q <= `RST_ZERO;
    end else begin
      if (wr_page_select) page_select_q <= reg_wdata_in;
      if (wr_enable_a) enable_a_q <= reg_wdata_in & `MASK_FUNCTION_ENABLE_A;
      if (wr_enable_b) enable_b_q <= reg_wdata_in & `MASK_FUNCTION_ENABLE_B;
      if (wr_page_address) page_address_q <= reg_wdata_in;
      if (wr_page_value) page_value_q <= reg_wdata_in;
      if (wr_fn1) fn1_route_q <= reg_wdata_in & `MASK_FUNCTION_ROUTING;
      if (wr_sm1) sm1_route_q <= reg_wdata_in;
      if (wr_lc1) lc1_route_q <= reg_wdata_in & `MASK_LEARNING_CORE_ROUTING;
      if (wr_fn2) fn2_route_q <= reg_wdata_in & `MASK_FUNCTION_ROUTING;
    end
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= `RST_ZERO;
    end else if (rd_ok) begin
      rdata_q <= read_mux;
    end
  end
  assign reg_rdata_out = rdata_q;

  // enable bits
  wire lc_first_en = enable_a_q[`BIT_LEARNING_CORE_FIRST];
  wire lc_after_en = enable_b_q[`BIT_LEARNING_CORE_AFTER];
  wire sm_en = enable_b_q[`BIT_STATE_MACHINE];
  wire algo_en = |(enable_a_q & 8'h3A);

  exec_sequencer #(.STAGE_LEN(STAGE_LEN)) u_seq (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sample_tick_in(sample_tick_in),
    .lc_first_en_in(lc_first_en),
    .sm_en_in(sm_en),
    .lc_after_en_in(lc_after_en),
    .algo_en_in(algo_en),
    .stage_out(stage),
    .busy_out(seq_busy),
    .overrun_out(seq_overrun)
  );

  page_memory #(.AW(PAGE_ADDR_W)) u_mem (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .port(pmem.mem)
  );

  // overrun and idle flags
  // the new overrun wins over a clearing status read in the same cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overrun_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      overrun_q <= seq_overrun | (overrun_q & ~rd_status);
      idle_q <= ~seq_busy;
    end
  end

  assign significant_motion_run_out = enable_a_q[`BIT_SIGNIFICANT_MOTION];
  assign tilt_run_out = enable_a_q[`BIT_TILT];
  assign step_counter_run_out = enable_a_q[`BIT_STEP_COUNTER];
  assign fusion_rotation_run_out = enable_a_q[`BIT_FUSION_ROTATION];
  assign queue_compression_active_out = enable_b_q[`BIT_QUEUE_COMPRESSION] & runtime_compression_enable_in;
  // state machines live only in their stage
  assign state_machine_run_out = (stage == EXEC_SM);
  assign learning_core_run_out = (stage == EXEC_LC_FIRST) | (stage == EXEC_LC_AFTER);
  assign exec_stage_out = stage;

  // event vector: step, tilt, motion, long counter, 8 state machines, 4 learning core
  wire [15:0] ev_now = {learning_core_event_in, state_machine_event_in, long_counter_event_in,
                        significant_motion_event_in, tilt_event_in, step_event_in};

  // request latch
  // per event: held while latching, service clears, a fresh event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_latch
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          latched_q[gi] <= 1'b0;
        end else if (function_interrupt_latch_in) begin
          latched_q[gi] <= ev_now[gi] | (latched_q[gi] & ~interrupt_service_in);
        end else begin
          latched_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  wire [15:0] ev_src = function_interrupt_latch_in ? (latched_q | ev_now) : ev_now;

  // routing masks in event order
  wire [3:0] fn1_mask = {fn1_route_q[`BIT_LONG_COUNTER_ROUTE], fn1_route_q[`BIT_SIGNIFICANT_MOTION_ROUTE],
                         fn1_route_q[`BIT_TILT_ROUTE], fn1_route_q[`BIT_STEP_ROUTE]};
  wire [3:0] fn2_mask = {fn2_route_q[`BIT_LONG_COUNTER_ROUTE], fn2_route_q[`BIT_SIGNIFICANT_MOTION_ROUTE],
                         fn2_route_q[`BIT_TILT_ROUTE], fn2_route_q[`BIT_STEP_ROUTE]};

  wire pin1_fn = first_pin_function_gate_in & |(ev_src[3:0] & fn1_mask);
  // state machine and learning core events
  // learning core routing is not behind the main gate
  wire pin1_sm = first_pin_function_gate_in & |(ev_src[11:4] & sm1_route_q);
  wire pin1_lc = |(ev_src[15:12] & lc1_route_q[3:0]);
  wire pin2_fn = second_pin_function_gate_in & |(ev_src[3:0] & fn2_mask);

  // pin or
  // pins are registered so they never glitch on decode
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
    end else begin
      pin1_q <= pin1_fn | pin1_sm | pin1_lc;
      pin2_q <= pin2_fn;
    end
  end
  assign first_interrupt_pin_out = pin1_q;
  assign second_interrupt_pin_out = pin2_q;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_lc_first_order: assert property (
    (stage == EXEC_SM && $past(stage) != EXEC_SM && lc_first_en) |-> $past(stage) == EXEC_LC_FIRST)
    else $error("state machines started without learning core first");
  a_lc_after_order: assert property (
    (stage == EXEC_LC_AFTER && $past(stage) != EXEC_LC_AFTER && sm_en) |-> $past(stage) == EXEC_SM)
    else $error("learning core after did not follow state machines");
  a_overrun_set: assert property (
    (sample_tick_in && seq_busy) |=> overrun_q ##1 (overrun_q || $past(rd_status)))
    else $error("overrun not flagged on late pass");
  a_idle_follow: assert property (
    $past(rstn_in) |-> (idle_q == !$past(seq_busy)))
    else $error("idle flag does not track pass state");
  a_pin1_step: assert property (
    (step_event_in && first_pin_function_gate_in && fn1_route_q[`BIT_STEP_ROUTE]) |=> first_interrupt_pin_out)
    else $error("routed step event missing on first pin");
  a_pin1_gated: assert property (
    (!first_pin_function_gate_in && lc1_route_q == 8'h00) |=> !first_interrupt_pin_out)
    else $error("first pin asserted with gate closed");
  a_pin2_tilt: assert property (
    (tilt_event_in && second_pin_function_gate_in && fn2_route_q[`BIT_TILT_ROUTE]) |=> second_interrupt_pin_out)
    else $error("routed tilt event missing on second pin");
  a_latch_hold: assert property (
    (function_interrupt_latch_in && !interrupt_service_in) |=> ((latched_q & $past(latched_q)) == $past(latched_q)))
    else $error("latched request dropped before service");
  a_bank_blocked: assert property (
    (!embedded_bank_access_in && reg_wr_in) |=> ($stable(enable_a_q) && $stable(fn1_route_q)))
    else $error("write landed while bank not selected");
  a_status_reserved: assert property (
    (rd_ok && reg_addr_in == `OFS_EXECUTION_STATUS) |=> reg_rdata_out[7:2] == 6'h00)
    else $error("status reserved bits not zero");
  a_page_write_gate: assert property (
    pmem.wr_en |-> (page_write_mode_in && embedded_bank_access_in))
    else $error("page written without write mode");
endmodule

// >>> host_model.sv
`timescale 1ns/1ps
// host side of the register port
module host_model (
  // clock and read data
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  // register strobes
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write strobe, launched after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h02) d[0] = 1'b1;
    case (a)
      8'h04: d = d & 8'hBA;
      8'h05: d = d & 8'h19;
      8'h0A, 8'h0E: d = d & 8'hB8;
      8'h0D: d = d & 8'h0F;
      default: d = d;
    endcase
    @(posedge core_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge core_clk_in);
    wr_out <= 1'b0;
  endtask
  // read data is registered, taken just after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge core_clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule

// >>> embedded_function_control_bank_test.sv
`timescale 1ns/1ps
module embedded_function_control_bank_test;
  import efb_pkg::*;
  logic core_clk_in, rstn_in;
  logic acc, rt, pwm, prm, lat, g1, g2, tick, svc;
  logic [15:0] ev; // lc, sm, long, sig, tilt, step
  logic [7:0] addr, wdata, d;
  logic wr, rd;
  byte_t rdata;
  logic sm_r, tl_r, st_r, fu_r, qc, smr, lcr, p1, p2;
  exec_stage_e stg;
  int miscompares = 0;
  int comparisons = 0;
  host_model host (.core_clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  embedded_function_control_bank DUT (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .embedded_bank_access_in(acc), .runtime_compression_enable_in(rt),
    .page_write_mode_in(pwm), .page_read_mode_in(prm), .function_interrupt_latch_in(lat),
    .first_pin_function_gate_in(g1), .second_pin_function_gate_in(g2),
    .sample_tick_in(tick), .interrupt_service_in(svc), .step_event_in(ev[0]),
    .tilt_event_in(ev[1]), .significant_motion_event_in(ev[2]), .long_counter_event_in(ev[3]),
    .state_machine_event_in(ev[11:4]), .learning_core_event_in(ev[15:12]),
    .significant_motion_run_out(sm_r), .tilt_run_out(tl_r), .step_counter_run_out(st_r),
    .fusion_rotation_run_out(fu_r), .queue_compression_active_out(qc),
    .state_machine_run_out(smr), .learning_core_run_out(lcr), .exec_stage_out(stg),
    .first_interrupt_pin_out(p1), .second_interrupt_pin_out(p2));
  // free-running 50 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // byte results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t byte %h want %h", $time, g, e);
    end
  endtask
  // single-bit results
  task automatic chkb(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t bit %b want %b", $time, g, e);
    end
  endtask
  // register readback
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  // one-cycle pulse, pins seen one cycle after the event edge
  task automatic pulse(input logic [15:0] v, input logic e1, input logic e2);
    @(posedge core_clk_in);
    ev <= v;
    @(posedge core_clk_in);
    ev <= 16'h0000;
    #1;
    chkb(p1, e1);
    chkb(p2, e2);
  endtask
  // sample tick, stage seen just after the taking edge
  task automatic tk;
    @(posedge core_clk_in);
    tick <= 1'b1;
    @(posedge core_clk_in);
    tick <= 1'b0;
    #1;
  endtask
  // watchdog sized well above the run length
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
  initial begin
    {acc, rt, pwm, prm, lat, g1, g2, tick, svc} = 9'h000;
    ev = 16'h0000;
    rstn_in = 1'b0;
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    acc <= 1'b1;
    rchk(8'h02, 8'h01);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    foreach (ev[i]) if (i >= 10 && i <= 14 && i != 12) rchk(i[7:0], 8'h00);
    rchk(8'h07, 8'h01);
    rchk(8'h03, 8'h00);
    host.wr(8'h04, 8'h3A);
    #1 chk({4'h0, sm_r, tl_r, st_r, fu_r}, 8'h0F);
    rchk(8'h04, 8'h3A);
    // bank closed: write dropped
    acc <= 1'b0;
    host.wr(8'h04, 8'h00);
    acc <= 1'b1;
    rchk(8'h04, 8'h3A);
    host.wr(8'h05, 8'h08);
    #1 chkb(qc, 1'b0);
    rt <= 1'b1;
    @(posedge core_clk_in);
    #1 chkb(qc, 1'b1);
    // only one learning core order bit at a time
    host.wr(8'h04, 8'h80);
    host.wr(8'h05, 8'h01);
    tk();
    chk(8'(stg), 8'(EXEC_LC_FIRST));
    chkb(lcr, 1'b1);
    repeat (4) @(posedge core_clk_in);
    #1 chk(8'(stg), 8'(EXEC_SM));
    chkb(smr, 1'b1);
    tk();
    repeat (8) @(posedge core_clk_in);
    rchk(8'h07, 8'h03);
    rchk(8'h07, 8'h01);
    host.wr(8'h04, 8'h00);
    host.wr(8'h05, 8'h11);
    tk();
    chk(8'(stg), 8'(EXEC_SM));
    repeat (4) @(posedge core_clk_in);
    #1 chk(8'(stg), 8'(EXEC_LC_AFTER));
    chkb(lcr, 1'b1);
    repeat (6) @(posedge core_clk_in);
    // indirect page write then read back
    pwm <= 1'b1;
    host.wr(8'h02, 8'h30);
    host.wr(8'h08, 8'h05);
    host.wr(8'h09, 8'hA5);
    pwm <= 1'b0;
    // held value changes, page byte must not
    host.wr(8'h09, 8'h5A);
    prm <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rchk(8'h09, 8'hA5);
    prm <= 1'b0;
    rchk(8'h09, 8'h5A);
    rchk(8'h02, 8'h31);
    host.wr(8'h0A, 8'h08);
    pulse(16'h0001, 1'b0, 1'b0);
    g1 <= 1'b1;
    pulse(16'h0001, 1'b1, 1'b0);
    @(posedge core_clk_in);
    #1 chkb(p1, 1'b0);
    host.wr(8'h0B, 8'h80);
    pulse(16'h0800, 1'b1, 1'b0);
    host.wr(8'h0D, 8'h01);
    pulse(16'h1000, 1'b1, 1'b0);
    host.wr(8'h0E, 8'h90);
    pulse(16'h0008, 1'b0, 1'b0);
    g2 <= 1'b1;
    pulse(16'h0008, 1'b0, 1'b1);
    pulse(16'h0002, 1'b0, 1'b1);
    lat <= 1'b1;
    pulse(16'h0001, 1'b1, 1'b0);
    repeat (3) @(posedge core_clk_in);
    #1 chkb(p1, 1'b1);
    @(posedge core_clk_in);
    svc <= 1'b1;
    @(posedge core_clk_in);
    svc <= 1'b0;
    @(posedge core_clk_in);
    #1 chkb(p1, 1'b0);
    end_sim();
  end
endmodule
